// ==== hw/pmp_wait_pkg.sv ====
// Shared constants and types for the parallel port wait and pin logic
package pmp_wait_pkg;

  // Register select codes on the internal register port
  localparam logic [7:0] ADDR_WAIT_TIMING = 8'h60;
  localparam logic [7:0] ADDR_UPPER_PIN_ENABLE = 8'h61;
  localparam logic [7:0] ADDR_TIMER2_SHARED = 8'h62;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h63;

  // Field positions
  localparam int SHARED_SELECT_BIT = 4;
  localparam int TTL_SELECT_BIT = 0;

  // Reset values
  localparam logic [7:0] WAIT_TIMING_RESET = 8'h00;
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic [7:0] TIMER2_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic TTL_SELECT_RESET = 1'b0;
  localparam logic SHARED_SELECT_RESET = 1'b0;

  // Strobe code that forces a single-cycle access
  localparam logic [3:0] STROBE_NO_WAIT = 4'h0;

  // Phase counter
  localparam int COUNT_W = 5;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 5'h01;

  typedef struct packed {
    logic [1:0] dataSetupWait;
    logic [3:0] strobeExtraWait;
    logic [1:0] dataHoldWait;
  } waitTiming_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [7:0] data;
  } sfrRequest_t;

  typedef enum {ACC_IDLE, ACC_SETUP, ACC_STROBE, ACC_HOLD} accessState_t;

endpackage

// ==== hw/phase_timer.sv ====
// Down counter that times one access phase in instruction cycles
module phase_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load
  input wire logic load,
  input wire logic [pmp_wait_pkg::COUNT_W-1:0] loadValue,
  // Cycles left in the phase
  output logic [pmp_wait_pkg::COUNT_W-1:0] remaining
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      remaining <= pmp_wait_pkg::COUNT_ZERO;
    else if (load)
      remaining <= loadValue;
    else if (remaining != pmp_wait_pkg::COUNT_ZERO)
      remaining <= remaining - pmp_wait_pkg::COUNT_ONE;
  end

endmodule // phase_timer

// ==== hw/parallel_port_wait_and_pin_enable.sv ====
// Parallel master port access timing, pin enables and input buffer select
module parallel_port_wait_and_pin_enable
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire pmp_wait_pkg::sfrRequest_t sfrReq,
  output logic [7:0] sfrReadData,
  // Access request
  input wire logic accessStart,
  input wire logic accessWrite,
  // Access phases
  output logic accessBusy,
  output logic accessIsWrite,
  output logic setupPhase,
  output logic strobeActive,
  output logic holdPhase,
  output logic accessDone,
  // Pin configuration
  output logic [7:0] upperPinEnable,
  output logic ttlInputSelect
);

  logic [7:0] waitTimingReg;
  logic [7:0] timer2Count;
  logic sharedAddressSelect;
  pmp_wait_pkg::waitTiming_t timing;
  pmp_wait_pkg::waitTiming_t timingLatched;
  pmp_wait_pkg::accessState_t state;
  logic timerLoad;
  logic [pmp_wait_pkg::COUNT_W-1:0] timerValue;
  logic [pmp_wait_pkg::COUNT_W-1:0] remaining;
  logic timerZero;
  logic padSelected;
  logic startTaken;

  function automatic logic [pmp_wait_pkg::COUNT_W-1:0] toCount
    (input logic [3:0] code);
    toCount = {1'b0, code};
  endfunction

  function automatic logic isAddr(input pmp_wait_pkg::sfrRequest_t r,
                                  input logic [7:0] a);
    isAddr = (r.addr == a);
  endfunction

  assign timing = pmp_wait_pkg::waitTiming_t'(waitTimingReg);
  assign timerZero = (remaining == pmp_wait_pkg::COUNT_ZERO);
  assign startTaken = (state == pmp_wait_pkg::ACC_IDLE) && accessStart;
  assign padSelected = isAddr(sfrReq, pmp_wait_pkg::ADDR_TIMER2_SHARED)
                       && sharedAddressSelect;

  // Register writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitTimingReg <= pmp_wait_pkg::WAIT_TIMING_RESET;
      upperPinEnable <= pmp_wait_pkg::PIN_ENABLE_RESET;
      timer2Count <= pmp_wait_pkg::TIMER2_RESET;
      sharedAddressSelect <= pmp_wait_pkg::SHARED_SELECT_RESET;
    end
    else if (sfrReq.write)
    begin
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_WAIT_TIMING))
        waitTimingReg <= sfrReq.data;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE))
        upperPinEnable <= sfrReq.data;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_TIMER2_SHARED)
          && !sharedAddressSelect)
        timer2Count <= sfrReq.data;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_WATCHDOG_CONTROL))
        sharedAddressSelect <= sfrReq.data[pmp_wait_pkg::SHARED_SELECT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ttlInputSelect <= pmp_wait_pkg::TTL_SELECT_RESET;
    else if (sfrReq.write && padSelected)
      ttlInputSelect <= sfrReq.data[pmp_wait_pkg::TTL_SELECT_BIT];
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sfrReadData <= pmp_wait_pkg::READ_IDLE;
    else if (sfrReq.read)
    begin
      sfrReadData <= pmp_wait_pkg::READ_IDLE;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_WAIT_TIMING))
        sfrReadData <= waitTimingReg;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE))
        sfrReadData <= upperPinEnable;
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_TIMER2_SHARED))
      begin
        if (sharedAddressSelect)
          sfrReadData[pmp_wait_pkg::TTL_SELECT_BIT] <= ttlInputSelect;
        else
          sfrReadData <= timer2Count;
      end
      if (isAddr(sfrReq, pmp_wait_pkg::ADDR_WATCHDOG_CONTROL))
        sfrReadData[pmp_wait_pkg::SHARED_SELECT_BIT] <= sharedAddressSelect;
    end
  end

  // Timing snapshot so a mid-access write cannot bend the phases
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timingLatched <= pmp_wait_pkg::waitTiming_t'(
        pmp_wait_pkg::WAIT_TIMING_RESET);
      accessIsWrite <= 1'b0;
    end
    else if (startTaken)
    begin
      timingLatched <= timing;
      accessIsWrite <= accessWrite;
    end
  end

  // Phase length loads
  always_comb
  begin
    timerLoad = 1'b0;
    timerValue = pmp_wait_pkg::COUNT_ZERO;
    case (state)
      pmp_wait_pkg::ACC_IDLE:
      begin
        timerLoad = accessStart;
        if (timing.strobeExtraWait == pmp_wait_pkg::STROBE_NO_WAIT)
          timerValue = pmp_wait_pkg::COUNT_ZERO;
        else
          timerValue = toCount({2'b00, timing.dataSetupWait});
      end
      pmp_wait_pkg::ACC_SETUP:
      begin
        timerLoad = timerZero;
        timerValue = toCount(timingLatched.strobeExtraWait);
      end
      pmp_wait_pkg::ACC_STROBE:
      begin
        timerLoad = timerZero;
        timerValue = toCount({2'b00, timingLatched.dataHoldWait});
      end
      default:
      begin
        timerLoad = 1'b0;
        timerValue = pmp_wait_pkg::COUNT_ZERO;
      end
    endcase
  end

  phase_timer phaseTimer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(timerLoad),
    .loadValue(timerValue),
    .remaining(remaining)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pmp_wait_pkg::ACC_IDLE;
      accessBusy <= 1'b0;
      setupPhase <= 1'b0;
      strobeActive <= 1'b0;
      holdPhase <= 1'b0;
      accessDone <= 1'b0;
    end
    else
    begin
      accessDone <= 1'b0;
      case (state)
        pmp_wait_pkg::ACC_IDLE:
          if (accessStart)
          begin
            accessBusy <= 1'b1;
            if (timing.strobeExtraWait == pmp_wait_pkg::STROBE_NO_WAIT)
            begin
              state <= pmp_wait_pkg::ACC_STROBE;
              strobeActive <= 1'b1;
            end
            else
            begin
              state <= pmp_wait_pkg::ACC_SETUP;
              setupPhase <= 1'b1;
            end
          end
        pmp_wait_pkg::ACC_SETUP:
          if (timerZero)
          begin
            state <= pmp_wait_pkg::ACC_STROBE;
            setupPhase <= 1'b0;
            strobeActive <= 1'b1;
          end
        pmp_wait_pkg::ACC_STROBE:
          if (timerZero)
          begin
            strobeActive <= 1'b0;
            if (timingLatched.strobeExtraWait ==
                pmp_wait_pkg::STROBE_NO_WAIT)
            begin
              state <= pmp_wait_pkg::ACC_IDLE;
              accessBusy <= 1'b0;
              accessDone <= 1'b1;
            end
            else
            begin
              state <= pmp_wait_pkg::ACC_HOLD;
              holdPhase <= 1'b1;
            end
          end
        pmp_wait_pkg::ACC_HOLD:
          if (timerZero)
          begin
            state <= pmp_wait_pkg::ACC_IDLE;
            holdPhase <= 1'b0;
            accessBusy <= 1'b0;
            accessDone <= 1'b1;
          end
        default:
        begin
          state <= pmp_wait_pkg::ACC_IDLE;
          accessBusy <= 1'b0;
          setupPhase <= 1'b0;
          strobeActive <= 1'b0;
          holdPhase <= 1'b0;
        end
      endcase
    end
  end

  // Phase length counters for checking
  logic [4:0] setupLen;
  logic [4:0] strobeLen;
  logic [4:0] holdLen;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setupLen <= 5'h00;
      strobeLen <= 5'h00;
      holdLen <= 5'h00;
    end
    else
    begin
      setupLen <= setupPhase ? setupLen + 5'h01 : 5'h00;
      strobeLen <= strobeActive ? strobeLen + 5'h01 : 5'h00;
      holdLen <= holdPhase ? holdLen + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence strobeEnds;
    $fell(strobeActive);
  endsequence

  sequence singleCycleAccess;
    strobeActive && !setupPhase ##1 !strobeActive && accessDone;
  endsequence

  AST_SETUP_LENGTH: assert property ($fell(setupPhase) |->
    $past(setupLen) == {3'b000, timingLatched.dataSetupWait})
    else $error("setup phase length wrong");

  AST_STROBE_LENGTH: assert property (strobeEnds |->
    $past(strobeLen) == {1'b0, timingLatched.strobeExtraWait})
    else $error("strobe length wrong");

  AST_SINGLE_CYCLE: assert property (startTaken &&
    timing.strobeExtraWait == pmp_wait_pkg::STROBE_NO_WAIT
    |=> singleCycleAccess)
    else $error("zero strobe code access not single cycle");

  AST_HOLD_LENGTH: assert property ($fell(holdPhase) |->
    $past(holdLen) == {3'b000, timingLatched.dataHoldWait} && accessDone)
    else $error("hold length wrong");

  AST_PIN_ENABLE: assert property (sfrReq.write &&
    isAddr(sfrReq, pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE)
    |=> upperPinEnable == $past(sfrReq.data))
    else $error("pin enable not written");

  AST_TTL_WRITE: assert property (sfrReq.write && padSelected
    |=> ttlInputSelect == $past(sfrReq.data[pmp_wait_pkg::TTL_SELECT_BIT]))
    else $error("ttl select not written");

  AST_SHARED_GATE: assert property (sfrReq.write &&
    isAddr(sfrReq, pmp_wait_pkg::ADDR_TIMER2_SHARED) && !sharedAddressSelect
    |=> $stable(ttlInputSelect) && timer2Count == $past(sfrReq.data))
    else $error("pad register reached without select");

  AST_PHASE_ORDER: assert property ($fell(setupPhase) |->
    strobeActive ##1 strobeActive[*1])
    else $error("strobe does not follow setup");

  AST_HOLD_AFTER_STROBE: assert property (strobeEnds ##0
    (timingLatched.strobeExtraWait != pmp_wait_pkg::STROBE_NO_WAIT)
    |-> holdPhase && !setupPhase)
    else $error("hold does not follow strobe");

endmodule // parallel_port_wait_and_pin_enable

// ==== testbench/ext_device_model.sv ====
// Far-side device model that times each phase of an access
module ext_device_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Phase signals from the port
  input wire logic setupPhase,
  input wire logic strobeActive,
  input wire logic holdPhase,
  input wire logic accessDone,
  // Lengths seen in the last access, and a sticky phase order error flag
  output logic [7:0] setupLen,
  output logic [7:0] strobeLen,
  output logic [7:0] holdLen,
  output logic orderBad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] nSetup;
  logic [7:0] nStrobe;
  logic [7:0] nHold;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nSetup <= 8'h00;
      nStrobe <= 8'h00;
      nHold <= 8'h00;
      setupLen <= 8'h00;
      strobeLen <= 8'h00;
      holdLen <= 8'h00;
      orderBad <= 1'b0;
    end
    else if (accessDone)
    begin
      setupLen <= nSetup;
      strobeLen <= nStrobe;
      holdLen <= nHold;
      nSetup <= 8'h00;
      nStrobe <= 8'h00;
      nHold <= 8'h00;
    end
    else
    begin
      nSetup <= nSetup + {7'h00, setupPhase};
      nStrobe <= nStrobe + {7'h00, strobeActive};
      nHold <= nHold + {7'h00, holdPhase};
      // Phase seen after a later phase began
      if ((setupPhase && (nStrobe != 8'h00 || nHold != 8'h00))
          || (strobeActive && nHold != 8'h00))
        orderBad <= 1'b1;
    end
  end
endmodule // ext_device_model

// ==== testbench/parallel_port_wait_and_pin_enable_tb.sv ====
// Self-checking bench for the port timing and pin enable block
module parallel_port_wait_and_pin_enable_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n;
  pmp_wait_pkg::sfrRequest_t sfrReq;
  logic [7:0] sfrReadData;
  logic accessStart;
  logic accessWrite;
  logic accessBusy;
  logic accessIsWrite;
  logic setupPhase;
  logic strobeActive;
  logic holdPhase;
  logic accessDone;
  logic [7:0] upperPinEnable;
  logic ttlInputSelect;
  logic [7:0] setupLen;
  logic [7:0] strobeLen;
  logic [7:0] holdLen;
  logic orderBad;
  int num_errors;
  int n_tests;
  logic [7:0] rd;
  logic [7:0] tv [5] = '{8'hc0, 8'h95, 8'h69, 8'h3f, 8'hc4};

  parallel_port_wait_and_pin_enable u_dut (.clk(clk), .rst_n(rst_n),
    .sfrReq(sfrReq), .sfrReadData(sfrReadData),
    .accessStart(accessStart), .accessWrite(accessWrite),
    .accessBusy(accessBusy), .accessIsWrite(accessIsWrite),
    .setupPhase(setupPhase), .strobeActive(strobeActive),
    .holdPhase(holdPhase), .accessDone(accessDone),
    .upperPinEnable(upperPinEnable), .ttlInputSelect(ttlInputSelect));

  ext_device_model u_dev (.clk(clk), .rst_n(rst_n),
    .setupPhase(setupPhase), .strobeActive(strobeActive),
    .holdPhase(holdPhase), .accessDone(accessDone),
    .setupLen(setupLen), .strobeLen(strobeLen), .holdLen(holdLen),
    .orderBad(orderBad));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfrReq <= {a, 1'b1, 1'b0, d};
    @(posedge clk);
    sfrReq <= {8'h00, 1'b0, 1'b0, 8'h00};
    #1;
  endtask

  task automatic reg_read(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrReq <= {a, 1'b0, 1'b1, 8'h00};
    @(posedge clk);
    sfrReq <= {8'h00, 1'b0, 1'b0, 8'h00};
    #1;
    d = sfrReadData;
  endtask

  task automatic run_access(logic w, logic [7:0] t);
    int k;
    logic [1:0] b;
    logic [3:0] m;
    logic [1:0] e;
    b = t[7:6];
    m = t[5:2];
    e = t[1:0];
    @(posedge clk);
    accessStart <= 1'b1;
    accessWrite <= w;
    @(posedge clk);
    accessStart <= 1'b0;
    #1;
    check8("busy", 8'h01, {7'h00, accessBusy});
    for (k = 0; k < 40 && accessDone !== 1'b1; k++)
      @(posedge clk) #1;
    if (k == 40)
    begin
      num_errors++;
      results();
    end
    check8("busy at done", 8'h00, {7'h00, accessBusy});
    @(posedge clk) #1;
    check8("done pulse", 8'h00, {7'h00, accessDone});
    check8("write flag", {7'h00, w}, {7'h00, accessIsWrite});
    if (m == 4'h0)
    begin
      check8("setup", 8'h00, setupLen);
      check8("strobe", 8'h01, strobeLen);
      check8("hold", 8'h00, holdLen);
    end
    else
    begin
      check8("setup", {6'h00, b} + 8'h01, setupLen);
      check8("strobe", {4'h0, m} + 8'h01, strobeLen);
      check8("hold", {6'h00, e} + 8'h01, holdLen);
    end
  endtask

  initial
  begin
    num_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    sfrReq = {8'h00, 1'b0, 1'b0, 8'h00};
    accessStart = 1'b0;
    accessWrite = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(pmp_wait_pkg::ADDR_WAIT_TIMING, rd);
    check8("timing reset", 8'h00, rd);
    reg_read(pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE, rd);
    check8("enable reset", 8'h00, rd);
    check8("ttl reset", 8'h00, {7'h00, ttlInputSelect});
    for (int i = 0; i < 5; i++)
    begin
      reg_write(pmp_wait_pkg::ADDR_WAIT_TIMING, tv[i]);
      run_access(i[0], tv[i]);
    end
    check8("phase order", 8'h00, {7'h00, orderBad});
    reg_write(pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE, 8'hc0);
    check8("top pins", 8'hc0, upperPinEnable);
    reg_write(pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE, 8'h3f);
    check8("address pins", 8'h3f, upperPinEnable);
    reg_read(pmp_wait_pkg::ADDR_UPPER_PIN_ENABLE, rd);
    check8("enable read", 8'h3f, rd);
    reg_write(pmp_wait_pkg::ADDR_TIMER2_SHARED, 8'h01);
    check8("ttl unselected", 8'h00, {7'h00, ttlInputSelect});
    reg_write(pmp_wait_pkg::ADDR_WATCHDOG_CONTROL, 8'h10);
    reg_read(pmp_wait_pkg::ADDR_WATCHDOG_CONTROL, rd);
    check8("watchdog", 8'h10, rd);
    reg_write(pmp_wait_pkg::ADDR_TIMER2_SHARED, 8'h01);
    check8("ttl set", 8'h01, {7'h00, ttlInputSelect});
    reg_write(pmp_wait_pkg::ADDR_TIMER2_SHARED, 8'h00);
    check8("ttl clear", 8'h00, {7'h00, ttlInputSelect});
    reg_write(pmp_wait_pkg::ADDR_WATCHDOG_CONTROL, 8'h00);
    reg_read(pmp_wait_pkg::ADDR_TIMER2_SHARED, rd);
    check8("timer2 kept", 8'h01, rd);
    reg_read(8'h70, rd);
    check8("unmapped", 8'h00, rd);
    results();
  end
endmodule // parallel_port_wait_and_pin_enable_tb
